// ==== hw/pdc_pkg.sv ====
// Package for the phase detector control block: word layout, modes and lock filter counts
package pdc_pkg;
	// Control word layout
	localparam int WORD_W = 16;
	localparam logic [0:0] ADDR_REF = 1'h0;
	localparam int PUMP_MULT_HI = 15;
	localparam int PUMP_MULT_LO = 14;
	localparam int SENSE_BIT = 12;
	localparam int DET_MODE_HI = 11;
	localparam int DET_MODE_LO = 10;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// Detector state encodings
	localparam logic [1:0] DET_ON_MON_OFF = 2'h0;
	localparam logic [1:0] DET_ON_MON_ON = 2'h1;
	localparam logic [1:0] DET_BY_LOCK = 2'h2;
	localparam logic [1:0] DET_OFF = 2'h3;
	// Pump multiplier codes: 1.0, 1.5, 2.5, 4.0 times base current
	localparam logic [1:0] MULT_X1_0 = 2'h0;
	localparam logic [1:0] MULT_X1_5 = 2'h1;
	localparam logic [1:0] MULT_X2_5 = 2'h2;
	localparam logic [1:0] MULT_X4_0 = 2'h3;
	// Lock filter defaults; loss is counted three times faster than gain
	localparam int LOCK_CNT_W = 12;
	localparam logic [11:0] LOCK_MAX = 12'hFFF;
	localparam logic [11:0] LOCK_THRESH = 12'h800;
	localparam logic [11:0] LOCK_UP_STEP = 12'h001;
	localparam logic [11:0] LOCK_DOWN_STEP = 12'h003;

	typedef struct packed {
		logic [1:0] pump_mult;
		logic sense;
		logic [1:0] det_mode;
	} pdc_ctrl_s;

	typedef enum logic [1:0] {
		PDC_IDLE,
		PDC_UP,
		PDC_DOWN,
		PDC_RESET
	} pdc_pfd_e;
endpackage

// ==== hw/pdc_lock_filter.sv ====
// Saturating counter that models the filtered lock node
`timescale 1ns/1ps
module pdc_lock_filter
	import pdc_pkg::*;
#(
	parameter logic [11:0] THRESH = LOCK_THRESH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Events
	input wire logic ref_edge,
	input wire logic overlap,
	// Result
	output logic locked
);
	logic [LOCK_CNT_W-1:0] level;
	logic seen_overlap;

	// Overlap seen during the current reference cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			seen_overlap <= 1'b0;
		end else if (ref_edge) begin
			seen_overlap <= overlap;
		end else if (overlap) begin
			seen_overlap <= 1'b1;
		end
	end

	// Node charges slowly on clean cycles, discharges fast on overlap
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			level <= '0;
		end else if (overlap) begin
			level <= (level > LOCK_DOWN_STEP) ? level - LOCK_DOWN_STEP : '0;
		end else if (ref_edge && !seen_overlap && level < LOCK_MAX) begin
			level <= level + LOCK_UP_STEP;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			locked <= 1'b0;
		end else begin
			locked <= (level >= THRESH);
		end
	end
endmodule // pdc_lock_filter

// ==== hw/pdc_top.sv ====
// Phase detector control: bus capture, detector, monitor outputs and lock indication
`timescale 1ns/1ps
module pdc_top
	import pdc_pkg::*;
#(
	parameter logic [11:0] LOCK_THRESHOLD = LOCK_THRESH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Programming bus pins
	input wire logic [WORD_W-1:0] bus_data,
	input wire logic bus_addr,
	input wire logic bus_strobe,
	// Divider outputs from the counters
	input wire logic rf_div,
	input wire logic ref_div,
	// Counter control and RF buffer
	output logic counters_reset,
	output logic [WORD_W-1:0] rf_word,
	output logic rf_word_load,
	// Charge pump
	output logic pump_up,
	output logic pump_down,
	output logic [1:0] pump_mult,
	// Monitor outputs
	output logic mon_rf,
	output logic mon_ref,
	// Lock indication, low when locked
	output logic lock_b
);
	logic [WORD_W-1:0] data_s1, data_s2;
	logic addr_s1, addr_s2, strobe_s1, strobe_s2, strobe_d;
	logic rf_s1, rf_s2, rf_d, ref_s1, ref_s2, ref_d;
	logic [WORD_W-1:0] ctrl_word;
	pdc_ctrl_s ctrl;
	pdc_pfd_e pfd;
	logic det_a, det_b, edge_a, edge_b, ref_edge, det_enable, locked;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Data and address reset to all ones: open inputs pull high; strobe stages reset low
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			data_s1 <= '1;
			data_s2 <= '1;
			addr_s1 <= 1'b1;
			addr_s2 <= 1'b1;
			strobe_s1 <= 1'b0;
			strobe_s2 <= 1'b0;
			strobe_d <= 1'b0;
		end else begin
			data_s1 <= bus_data;
			data_s2 <= data_s1;
			addr_s1 <= bus_addr;
			addr_s2 <= addr_s1;
			strobe_s1 <= bus_strobe;
			strobe_s2 <= strobe_s1;
			strobe_d <= strobe_s2;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rf_s1 <= 1'b0;
			rf_s2 <= 1'b0;
			rf_d <= 1'b0;
			ref_s1 <= 1'b0;
			ref_s2 <= 1'b0;
			ref_d <= 1'b0;
		end else begin
			rf_s1 <= rf_div;
			rf_s2 <= rf_s1;
			rf_d <= rf_s2;
			ref_s1 <= ref_div;
			ref_s2 <= ref_s1;
			ref_d <= ref_s2;
		end
	end

	// ------------------------------------------------------------
	// Word capture on falling strobe
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_word <= CTRL_RESET;
			rf_word <= '0;
			rf_word_load <= 1'b0;
		end else begin
			rf_word_load <= 1'b0;
			if (strobe_d && !strobe_s2) begin
				if (addr_s2 == ADDR_REF) begin
					ctrl_word <= data_s2;
				end else begin
					rf_word <= data_s2;
					rf_word_load <= 1'b1;
				end
			end
		end
	end

	always_comb begin
		ctrl.pump_mult = ctrl_word[PUMP_MULT_HI:PUMP_MULT_LO];
		ctrl.sense = ctrl_word[SENSE_BIT];
		ctrl.det_mode = ctrl_word[DET_MODE_HI:DET_MODE_LO];
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			counters_reset <= 1'b0;
			pump_mult <= MULT_X1_0;
		end else begin
			counters_reset <= strobe_s2;
			pump_mult <= ctrl.pump_mult;
		end
	end

	// ------------------------------------------------------------
	// Phase/frequency detector
	// ------------------------------------------------------------
	// Sense bit swaps which divider leads the detector
	// Sense 0: reference leading (RF lagging) gives the sink pulse
	always_comb begin
		det_a = ctrl.sense ? ref_s2 : rf_s2;
		det_b = ctrl.sense ? rf_s2 : ref_s2;
		edge_a = det_a && !(ctrl.sense ? ref_d : rf_d);
		edge_b = det_b && !(ctrl.sense ? rf_d : ref_d);
		ref_edge = ref_s2 && !ref_d;
		case (ctrl.det_mode)
			DET_ON_MON_OFF: det_enable = 1'b1;
			DET_ON_MON_ON: det_enable = 1'b1;
			DET_BY_LOCK: det_enable = !locked;
			DET_OFF: det_enable = 1'b0;
			default: det_enable = 1'b0;
		endcase
	end

	// Up when det_a leads, down when det_b leads, cleared when both seen
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pfd <= PDC_IDLE;
		end else begin
			case (pfd)
				PDC_IDLE: begin
					if (edge_a && edge_b) pfd <= PDC_RESET;
					else if (edge_a) pfd <= PDC_UP;
					else if (edge_b) pfd <= PDC_DOWN;
				end
				PDC_UP: if (edge_b) pfd <= PDC_RESET;
				PDC_DOWN: if (edge_a) pfd <= PDC_RESET;
				PDC_RESET: pfd <= PDC_IDLE;
				default: pfd <= PDC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pump_up <= 1'b0;
			pump_down <= 1'b0;
		end else begin
			pump_up <= det_enable && !strobe_s2 && (pfd == PDC_UP);
			pump_down <= det_enable && !strobe_s2 && (pfd == PDC_DOWN);
		end
	end

	// ------------------------------------------------------------
	// Lock detection
	// ------------------------------------------------------------
	// Overlap: both divider edges seen, detector in the reset state
	pdc_lock_filter #(
		.THRESH(LOCK_THRESHOLD)
	) u_lock (
		.clock(clock),
		.rst_b(rst_b),
		.ref_edge(ref_edge),
		.overlap(pfd == PDC_RESET),
		.locked(locked)
	);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lock_b <= 1'b1;
		end else begin
			lock_b <= !locked;
		end
	end

	// ------------------------------------------------------------
	// Monitor outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mon_rf <= 1'b0;
			mon_ref <= 1'b0;
		end else if (ctrl.det_mode == DET_ON_MON_OFF) begin
			mon_rf <= 1'b0;
			mon_ref <= 1'b0;
		end else begin
			mon_rf <= ctrl.sense ? ref_s2 : rf_s2;
			mon_ref <= ctrl.sense ? rf_s2 : ref_s2;
		end
	end
endmodule // pdc_top

// ==== test/pdc_top_sva.sv ====
// Port checker for the phase detector control block
`timescale 1ns/1ps
module pdc_top_chk
	import pdc_pkg::*;
(
	// Clock, reset and bus
	input wire logic clock,
	input wire logic rst_b,
	input wire logic bus_addr,
	input wire logic bus_strobe,
	// Design outputs
	input wire logic counters_reset,
	input wire logic rf_word_load,
	input wire logic pump_up,
	input wire logic pump_down,
	input wire logic lock_b
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	rst_unlock_a: assert property ($rose(rst_b) |-> lock_b) else $error("lock at reset");
	pump_excl_a: assert property (!(pump_up && pump_down)) else $error("both pumps on");
	strobe_hold_a: assert property ($rose(bus_strobe) |-> ##[2:3] counters_reset)
		else $error("counters not held");
	strobe_free_a: assert property (!bus_strobe [*4] |-> !counters_reset)
		else $error("counters not released");
	pump_block_a: assert property (bus_strobe [*4] |-> !pump_up && !pump_down)
		else $error("pump active in strobe");
	load_pulse_a: assert property (rf_word_load |=> !rf_word_load)
		else $error("load pulse too long");
	rf_load_a: assert property ($fell(bus_strobe) && bus_addr |-> ##[2:4] rf_word_load)
		else $error("rf word not loaded");
	ref_noload_a: assert property ($fell(bus_strobe) && !bus_addr |-> !rf_word_load [*5])
		else $error("rf word loaded on ref write");
endmodule // pdc_top_chk
bind pdc_top pdc_top_chk pdc_top_chk_i (.clock(clock), .rst_b(rst_b), .bus_addr(bus_addr),
	.bus_strobe(bus_strobe), .counters_reset(counters_reset), .rf_word_load(rf_word_load),
	.pump_up(pump_up), .pump_down(pump_down), .lock_b(lock_b));

// ==== test/pdc_host.sv ====
// Host model driving the strobed programming bus
`timescale 1ns/1ps
module pdc_host
	import pdc_pkg::*;
(
	// Clock
	input wire logic clock,
	// Bus pins
	output logic [WORD_W-1:0] bus_data,
	output logic bus_addr,
	output logic bus_strobe
);
	initial {bus_data, bus_addr, bus_strobe} = '0;
	task automatic up(input logic a, input logic [WORD_W-1:0] d);
		@(negedge clock);
		bus_addr = a;
		bus_data = d;
		repeat (3) @(negedge clock);
		bus_strobe = 1'h1;
	endtask
	// Final data settles well before strobe falls; strobe kept short
	task automatic down(input logic [WORD_W-1:0] d);
		bus_data = d;
		repeat (4) @(negedge clock);
		bus_strobe = 1'h0;
		repeat (6) @(negedge clock);
	endtask
endmodule // pdc_host

// ==== test/pdc_top_tb_top.sv ====
// Testbench for the phase detector control block
`timescale 1ns/1ps
module pdc_top_tb_top
	import pdc_pkg::*;
;
	logic clock = 1'h0;
	logic rst_b = 1'h0;
	logic rf_div = 1'h0;
	logic ref_div = 1'h0;
	logic [WORD_W-1:0] bus_data, rf_word;
	logic bus_addr, bus_strobe, counters_reset, rf_word_load, pump_up, pump_down;
	logic mon_rf, mon_ref, lock_b;
	logic [1:0] pump_mult;
	int errors = 0;
	int comparisons = 0;
	always #10 clock = ~clock;
	pdc_host pdc_host_i (.clock(clock), .bus_data(bus_data), .bus_addr(bus_addr),
		.bus_strobe(bus_strobe));
	pdc_top #(.LOCK_THRESHOLD(12'h008)) pdc_top_i (.clock(clock), .rst_b(rst_b),
		.bus_data(bus_data), .bus_addr(bus_addr), .bus_strobe(bus_strobe), .rf_div(rf_div),
		.ref_div(ref_div), .counters_reset(counters_reset), .rf_word(rf_word),
		.rf_word_load(rf_word_load), .pump_up(pump_up), .pump_down(pump_down),
		.pump_mult(pump_mult), .mon_rf(mon_rf), .mon_ref(mon_ref), .lock_b(lock_b));
	task automatic complete_run();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic edges(input logic r, input logic f, input int n);
		ref_div = r;
		rf_div = f;
		wt(n);
	endtask
	task automatic wr(input logic a, input logic [WORD_W-1:0] d0, input logic [WORD_W-1:0] d1);
		pdc_host_i.up(a, d0);
		wt(4);
		chk(16'(counters_reset), 16'h1);
		chk(16'({pump_up, pump_down}), 16'h0);
		pdc_host_i.down(d1);
	endtask
	task automatic t_mult();
		for (int i = 0; i < 4; i++) begin
			wr(1'h0, 16'hFFFF, {i[1:0], 14'h0400});
			chk(16'(pump_mult), 16'(i));
		end
	endtask
	task automatic t_rf();
		wr(1'h1, 16'h1234, 16'hA5C3);
		chk(rf_word, 16'hA5C3);
		wr(1'h0, 16'h0000, 16'h0400);
		chk(rf_word, 16'hA5C3);
	endtask
	task automatic t_mon(input logic [WORD_W-1:0] w, input logic [1:0] exp);
		wr(1'h0, w, w);
		edges(1'h0, 1'h1, 6);
		chk(16'({mon_rf, mon_ref}), 16'(exp));
		edges(1'h0, 1'h0, 4);
	endtask
	task automatic t_pfd(input logic [WORD_W-1:0] w, input logic [1:0] exp);
		logic [1:0] seen;
		seen = 2'h0;
		wr(1'h0, w, w);
		edges(1'h1, 1'h1, 6);
		edges(1'h0, 1'h0, 3);
		ref_div = 1'h1;
		repeat (8) begin
			wt(1);
			seen = seen | {pump_up, pump_down};
		end
		edges(1'h1, 1'h1, 6);
		edges(1'h0, 1'h0, 3);
		chk(16'(seen), 16'(exp));
	endtask
	task automatic t_lock();
		wr(1'h0, 16'h0800, 16'h0800);
		edges(1'h1, 1'h0, 4);
		chk(16'({pump_up, pump_down}), 16'h1);
		edges(1'h0, 1'h0, 4);
		repeat (11) begin
			edges(1'h1, 1'h0, 4);
			edges(1'h0, 1'h0, 4);
		end
		chk(16'(lock_b), 16'h0);
		chk(16'({pump_up, pump_down}), 16'h0);
		wr(1'h0, 16'h0400, 16'h0400);
		repeat (14) begin
			edges(1'h1, 1'h0, 3);
			edges(1'h1, 1'h1, 3);
			edges(1'h0, 1'h0, 2);
		end
		chk(16'(lock_b), 16'h1);
	endtask
	initial begin
		wt(2);
		rst_b = 1'h1;
		wt(2);
		chk(16'({lock_b, pump_mult, mon_rf, mon_ref}), 16'h10);
		t_mult();
		t_rf();
		t_mon(16'h0400, 2'h2);
		t_mon(16'h1400, 2'h1);
		t_mon(16'h0000, 2'h0);
		t_pfd(16'h1400, 2'h2);
		t_pfd(16'h0400, 2'h1);
		t_pfd(16'h0C00, 2'h0);
		t_lock();
		complete_run();
	end
	initial begin
		#80000;
		errors++;
		complete_run();
	end
endmodule // pdc_top_tb_top
